// [design/csr_top.sv]
// Purpose: core status register bank with AXI4-Lite access
// Assumes: single clock, synchronous active-low reset, inputs synchronous
// Notes:   the op register issues one instruction to the arithmetic path
`timescale 1ns/1ps
module csr_top #(
  parameter int unsigned ADDR_W   = 12,
  parameter int unsigned WDT_BASE = csr_pkg::WDT_BASE_CYCLES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              input_only_pin,
  output logic                   wdt_timeout
);

  if (ADDR_W < 12 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must be 12..32");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  csr_pkg::csr_status_t st_r, st_nxt;      // status register
  logic [7:0]  tmr_r, tmr_nxt;             // timer_zero
  logic [7:0]  opt_r, opt_nxt;             // option register
  logic [7:0]  dir_r, dir_nxt;             // direction latch as written
  logic [7:0]  fsr_r, fsr_nxt;             // indirect pointer
  logic [7:0]  res_r, res_nxt;             // last result
  logic [4:0]  pcl_r, pcl_nxt;             // pc_high_latch
  logic [12:0] pc_r, pc_nxt;               // program counter
  logic [31:0] op_r, op_nxt;               // issued op word
  logic        go_r, go_nxt;               // op executes this cycle
  logic [8:0]  dadr_r, dadr_nxt;           // last direct address
  logic [8:0]  iadr_r, iadr_nxt;           // last indirect address
  logic        wto_r, wto_nxt;             // timeout pulse out
  logic        awr_r, awr_nxt, bv_r, bv_nxt, arr_r, arr_nxt, rv_r, rv_nxt;
  logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
  logic [31:0] rd_r, rd_nxt;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // status answers at the same low offset in every bank
  function automatic logic is_status(input logic [9:0] i);
    is_status = (i[9] == 1'b0) && (i[6:0] == csr_pkg::IDX_STATUS_LOW);
  endfunction

  function automatic logic is_mapped(input logic [9:0] i);
    is_mapped = is_status(i) || i == csr_pkg::IDX_TIMER_ZERO ||
                i == csr_pkg::IDX_PORT || i == csr_pkg::IDX_PC_LATCH ||
                i == csr_pkg::IDX_OPTION || i == csr_pkg::IDX_DIR ||
                i == csr_pkg::IDX_CORE_OP || i == csr_pkg::IDX_CORE_RES ||
                i == csr_pkg::IDX_ADDR;
  endfunction

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  csr_pkg::csr_op_t  opc;
  csr_pkg::csr_alu_t alu;
  logic [7:0] wreg, fval;
  logic [6:0] addr7;
  logic       dest_st, t0_tick, wdt_expire, wdt_clear;

  assign opc     = csr_pkg::csr_op_t'(op_r[csr_pkg::OP_CODE_LSB +: 4]);
  assign wreg    = op_r[csr_pkg::OP_W_LSB +: 8];
  assign addr7   = op_r[csr_pkg::OP_ADDR_LSB +: 7];
  // file destination is status when its low address matches in any bank
  assign dest_st = op_r[csr_pkg::OP_DEST_BIT] && (addr7 == csr_pkg::IDX_STATUS_LOW);
  assign fval    = dest_st ? st_r : op_r[csr_pkg::OP_F_LSB +: 8];
  assign wdt_clear = go_r && (opc == csr_pkg::CSR_OP_WATCHDOG_CLEAR_OP || opc == csr_pkg::CSR_OP_SLEEP);

  csr_alu u_alu (
    .op (opc),
    .w  (wreg),
    .f  (fval),
    .o  (alu)
  );

  csr_prescale #(.WDT_BASE(WDT_BASE)) u_pre (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .prescaler_assign_bit        (opt_r[csr_pkg::PSA_BIT]),
    .ps         (opt_r[2:0]),
    .wdt_clear  (wdt_clear),
    .t0_tick    (t0_tick),
    .wdt_expire (wdt_expire)
  );

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic [9:0] wr_idx, rd_idx;
  logic       wr_do, rd_do;

  assign wr_idx = awaddr[11:2];
  assign rd_idx = araddr[11:2];
  assign wr_do  = awr_r && awvalid && wvalid;   // both taken together
  assign rd_do  = arr_r && arvalid;

  // read value mux; direction bit of the input pin always reads one
  function automatic logic [31:0] rd_val(input logic [9:0] i);
    rd_val = 32'h0000_0000;
    if (is_status(i)) rd_val = {24'h0, st_r};
    else if (i == csr_pkg::IDX_TIMER_ZERO) rd_val = {24'h0, tmr_r};
    else if (i == csr_pkg::IDX_PORT) rd_val = {24'h0, 8'(input_only_pin) << csr_pkg::PIN_BIT};
    else if (i == csr_pkg::IDX_PC_LATCH) rd_val = {27'h0, pcl_r};
    else if (i == csr_pkg::IDX_OPTION) rd_val = {24'h0, opt_r};
    else if (i == csr_pkg::IDX_DIR)
      rd_val = {24'h0, dir_r | (8'h01 << csr_pkg::PIN_BIT)};
    else if (i == csr_pkg::IDX_CORE_OP) rd_val = op_r;
    else if (i == csr_pkg::IDX_CORE_RES) rd_val = {11'h0, pc_r, res_r};
    else if (i == csr_pkg::IDX_ADDR) rd_val = {7'h0, iadr_r, 7'h0, dadr_r};
  endfunction

  // handshake next state: accept write only with both channels valid
  always_comb begin
    awr_nxt = awvalid && wvalid && !awr_r && !bv_r;
    bv_nxt  = bv_r;
    br_nxt  = br_r;
    if (bv_r && bready) begin
      bv_nxt = 1'b0;
    end
    if (wr_do) begin
      bv_nxt = 1'b1;
      br_nxt = is_mapped(wr_idx) ? csr_pkg::RESP_OKAY : csr_pkg::RESP_SLVERR;
    end
    arr_nxt = arvalid && !arr_r && !rv_r;
    rv_nxt  = rv_r;
    rr_nxt  = rr_r;
    rd_nxt  = rd_r;
    if (rv_r && rready) begin
      rv_nxt = 1'b0;
    end
    if (rd_do) begin
      rv_nxt = 1'b1;
      rd_nxt = rd_val(rd_idx);
      rr_nxt = is_mapped(rd_idx) ? csr_pkg::RESP_OKAY : csr_pkg::RESP_SLVERR;
    end
  end

  // handshake registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awr_r <= 1'b0;
      bv_r  <= 1'b0;
      br_r  <= csr_pkg::RESP_OKAY;
      arr_r <= 1'b0;
      rv_r  <= 1'b0;
      rr_r  <= csr_pkg::RESP_OKAY;
      rd_r  <= 32'h0000_0000;
    end else if (ce) begin
      awr_r <= awr_nxt;
      bv_r  <= bv_nxt;
      br_r  <= br_nxt;
      arr_r <= arr_nxt;
      rv_r  <= rv_nxt;
      rr_r  <= rr_nxt;
      rd_r  <= rd_nxt;
    end
  end

  assign awready = awr_r;
  assign wready  = awr_r;
  assign bvalid  = bv_r;
  assign bresp   = br_r;
  assign arready = arr_r;
  assign rvalid  = rv_r;
  assign rresp   = rr_r;
  assign rdata   = rd_r;
  assign wdt_timeout = wto_r;

  // ----------------------------------------------------------------
  // core state next values
  // ----------------------------------------------------------------
  logic wr_ok;
  assign wr_ok = wr_do && wstrb[0];   // all registers but the 32-bit op word sit in byte lane 0

  always_comb begin
    st_nxt = st_r;  tmr_nxt = tmr_r; opt_nxt = opt_r; dir_nxt = dir_r;
    fsr_nxt = fsr_r; res_nxt = res_r; pcl_nxt = pcl_r; pc_nxt = pc_r;
    op_nxt = op_r;  dadr_nxt = dadr_r; iadr_nxt = iadr_r;
    go_nxt  = 1'b0;
    wto_nxt = wdt_expire;
    // timer zero: software load beats a count
    if (t0_tick) tmr_nxt = tmr_r + 8'h01;
    if (wr_ok) begin
      if (is_status(wr_idx)) begin
        // event flags keep their value on any software write
        st_nxt = {wdata[7:5], st_r.to, st_r.pd, wdata[2:0]};
      end
      if (wr_idx == csr_pkg::IDX_TIMER_ZERO) tmr_nxt = wdata[7:0];
      if (wr_idx == csr_pkg::IDX_PC_LATCH) pcl_nxt = wdata[4:0];
      if (wr_idx == csr_pkg::IDX_OPTION) opt_nxt = wdata[7:0];
      if (wr_idx == csr_pkg::IDX_DIR) dir_nxt = wdata[7:0];
      if (wr_idx == csr_pkg::IDX_ADDR) fsr_nxt = wdata[7:0];
      if (wr_idx == csr_pkg::IDX_CORE_OP) begin
        op_nxt = wdata;
        go_nxt = 1'b1;
      end
    end
    // watchdog expiry clears the time-out flag
    if (wdt_expire) st_nxt.to = 1'b0;
    if (go_r) begin
      dadr_nxt = {st_r.rp, addr7};
      iadr_nxt = {st_r.indirect_bank_select, fsr_r};
      pc_nxt   = pc_r + 13'h0001;
      if (alu.wr) res_nxt = alu.res;
      if (alu.wr && dest_st) begin
        // plain data write to the non-event bits
        st_nxt = {alu.res[7:5], st_r.to, st_r.pd, alu.res[2:0]};
      end
      // flag results override any data write to those bits
      if (alu.mask[2]) st_nxt.z  = alu.z;
      if (alu.mask[1]) st_nxt.dc = alu.dc;
      if (alu.mask[0]) st_nxt.c  = alu.c;
      case (opc)
        csr_pkg::CSR_OP_WATCHDOG_CLEAR_OP: begin
          st_nxt.to = 1'b1;
          st_nxt.pd = 1'b1;
        end
        csr_pkg::CSR_OP_SLEEP: begin
          st_nxt.to = 1'b1;
          st_nxt.pd = 1'b0;
        end
        // clearing status as a file leaves both carry flags alone
        csr_pkg::CSR_OP_CLEAR_FILE_OP: begin
          if (dest_st) begin
            st_nxt.dc = st_r.dc;
            st_nxt.c  = st_r.c;
          end
        end
        // upper counter bits come only from the holding latch
        csr_pkg::CSR_OP_GOTO: pc_nxt = {pcl_r, wreg};
        default: ;
      endcase
    end
  end

  // core state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r  <= csr_pkg::STATUS_RST;  tmr_r <= 8'h00;
      opt_r <= csr_pkg::OPTION_RST;  dir_r <= csr_pkg::DIR_RST;
      fsr_r <= 8'h00;  res_r <= 8'h00;  pcl_r <= 5'h00;
      pc_r  <= 13'h0000;  op_r <= 32'h0000_0000;  go_r <= 1'b0;
      dadr_r <= 9'h000;  iadr_r <= 9'h000;  wto_r <= 1'b0;
    end else if (ce) begin
      st_r  <= st_nxt;   tmr_r <= tmr_nxt;  opt_r <= opt_nxt;
      dir_r <= dir_nxt;  fsr_r <= fsr_nxt;  res_r <= res_nxt;
      pcl_r <= pcl_nxt;  pc_r  <= pc_nxt;   op_r  <= op_nxt;
      go_r  <= go_nxt;   dadr_r <= dadr_nxt; iadr_r <= iadr_nxt;
      wto_r <= wto_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_event_flag_keep: assert property (ce && wr_ok && is_status(wr_idx) && !wdt_expire
    |=> st_r.to == $past(st_r.to) && st_r.pd == $past(st_r.pd))
    else $error("software write changed event flags");
  chk_clear_file_op_status: assert property (ce && go_r && opc == csr_pkg::CSR_OP_CLEAR_FILE_OP && dest_st
    |=> st_r.z && st_r.rp == 2'b00 && !st_r.indirect_bank_select && st_r.c == $past(st_r.c) &&
        st_r.dc == $past(st_r.dc))
    else $error("clear of status gave wrong bits");
  chk_flag_block: assert property (ce && go_r && opc == csr_pkg::CSR_OP_ADD && dest_st
    |=> st_r.c == $past(alu.c) && st_r.z == $past(alu.z))
    else $error("flag write not blocked");
  chk_sleep_flags: assert property (ce && go_r && opc == csr_pkg::CSR_OP_SLEEP
    |=> st_r.to && !st_r.pd)
    else $error("sleep flags wrong");
  chk_wdt_to_clear: assert property (ce && wdt_expire && !go_r && !wr_ok
    |=> !st_r.to && wdt_timeout)
    else $error("expiry did not clear time-out");
  chk_dir_reads_one: assert property (ce && rd_do && rd_idx == csr_pkg::IDX_DIR
    |=> rvalid && rdata[csr_pkg::PIN_BIT])
    else $error("direction bit not one");
  chk_t0_direct: assert property (ce && opt_r[csr_pkg::PSA_BIT] && !wr_ok
    |=> tmr_r == $past(tmr_r) + 8'h01)
    else $error("timer zero not 1:1");
  chk_pc_latch_load: assert property (ce && go_r && opc == csr_pkg::CSR_OP_GOTO
    |=> pc_r[12:8] == $past(pcl_r) && pc_r[7:0] == $past(wreg))
    else $error("pc high not from latch");
  chk_mirror_status: assert property (ce && rd_do && is_status(rd_idx)
    |=> rdata[7:0] == $past(st_r))
    else $error("status mirror read wrong");

endmodule // csr_top

// [pkg/csr_pkg.sv]
// Purpose: shared constants and types of the core status register block
// Assumes: 32-bit AXI4-Lite data, one register per aligned word (byte = 4 x index)
// Notes:   register indices are kept as printed; byte address is index times four
package csr_pkg;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_TIMER_ZERO = 10'h001; // timer zero count
  localparam logic [6:0] IDX_STATUS_LOW = 7'h03;   // status, same in every bank
  localparam logic [9:0] IDX_PORT       = 10'h005; // port pins (input only pin)
  localparam logic [9:0] IDX_PC_LATCH   = 10'h00a; // pc_high_latch
  localparam logic [9:0] IDX_OPTION     = 10'h081; // option register
  localparam logic [9:0] IDX_DIR        = 10'h085; // port direction register
  localparam logic [9:0] IDX_CORE_OP    = 10'h040; // instruction issue word
  localparam logic [9:0] IDX_CORE_RES   = 10'h041; // result and program counter
  localparam logic [9:0] IDX_ADDR       = 10'h042; // fsr write, addresses read

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned PIN_BIT     = 5;     // input_only_pin position
  localparam int unsigned PSA_BIT     = 3;     // prescaler_assign_bit
  localparam int unsigned OP_W_LSB    = 0;     // working register operand
  localparam int unsigned OP_F_LSB    = 8;     // file operand value
  localparam int unsigned OP_ADDR_LSB = 16;    // 7-bit file address
  localparam int unsigned OP_DEST_BIT = 23;    // 1 = result goes to file
  localparam int unsigned OP_CODE_LSB = 24;    // operation code
  localparam logic [7:0]  STATUS_RST  = 8'h18; // both event flags set at power-up
  localparam logic [7:0]  OPTION_RST  = 8'hff;
  localparam logic [7:0]  DIR_RST     = 8'hff;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int unsigned WDT_BASE_CYCLES = 256; // watchdog base divide count

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CSR_OP_ADD   = 4'h0, CSR_OP_SUB   = 4'h1, CSR_OP_AND  = 4'h2,
    CSR_OP_OR    = 4'h3, CSR_OP_XOR   = 4'h4, CSR_OP_CLEAR_FILE_OP = 4'h5,
    CSR_OP_MOVE_W_TO_FILE_OP = 4'h6, CSR_OP_NIBBLE_SWAP_OP = 4'h7, CSR_OP_BCF  = 4'h8,
    CSR_OP_BSF   = 4'h9, CSR_OP_WATCHDOG_CLEAR_OP = 4'ha, CSR_OP_SLEEP = 4'hb,
    CSR_OP_GOTO  = 4'hc
  } csr_op_t;

  typedef struct packed {
    logic       indirect_bank_select;   // indirect_bank_select
    logic [1:0] rp;    // direct_bank_sel_hi, direct_bank_sel_lo
    logic       to;    // watchdog_expiry_flag
    logic       pd;    // powerdown_flag
    logic       z;     // zero flag
    logic       dc;    // nibble_carry_flag
    logic       c;     // carry flag
  } csr_status_t;

  typedef struct packed {
    logic [7:0] res;   // result value
    logic       wr;    // op writes a destination
    logic [2:0] mask;  // flags touched: z, dc, c
    logic       z;
    logic       dc;
    logic       c;
  } csr_alu_t;

endpackage

// [design/csr_alu.sv]
// Purpose: arithmetic unit producing result and zero/nibble/carry flags
// Assumes: purely combinational, sampled by the caller
// Notes:   subtraction adds the two's complement of the working operand
`timescale 1ns/1ps
module csr_alu (
  input  wire csr_pkg::csr_op_t op,
  input  wire logic [7:0]       w,
  input  wire logic [7:0]       f,
  output csr_pkg::csr_alu_t     o
);

  // ----------------------------------------------------------------
  // operation decode
  // ----------------------------------------------------------------
  logic [7:0] b;      // second adder operand
  logic       cin;    // carry in
  logic [8:0] sum;    // full sum with carry out
  logic [4:0] nib;    // low nibble sum

  always_comb begin
    b   = (op == csr_pkg::CSR_OP_SUB) ? ~w : w;
    cin = (op == csr_pkg::CSR_OP_SUB);
    sum = {1'b0, f} + {1'b0, b} + {8'h00, cin};
    nib = {1'b0, f[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    o   = '0;
    o.wr = 1'b1;
    case (op)
      csr_pkg::CSR_OP_ADD, csr_pkg::CSR_OP_SUB: begin
        o.res  = sum[7:0];
        o.mask = 3'h7;
      end
      csr_pkg::CSR_OP_AND:   begin o.res = f & w; o.mask = 3'h4; end
      csr_pkg::CSR_OP_OR:    begin o.res = f | w; o.mask = 3'h4; end
      csr_pkg::CSR_OP_XOR:   begin o.res = f ^ w; o.mask = 3'h4; end
      csr_pkg::CSR_OP_CLEAR_FILE_OP:  begin o.res = 8'h00; o.mask = 3'h4; end
      csr_pkg::CSR_OP_MOVE_W_TO_FILE_OP: o.res = w;                  // flags untouched
      csr_pkg::CSR_OP_NIBBLE_SWAP_OP: o.res = {f[3:0], f[7:4]};
      csr_pkg::CSR_OP_BCF:   o.res = f & ~(8'h01 << w[2:0]);
      csr_pkg::CSR_OP_BSF:   o.res = f | (8'h01 << w[2:0]);
      default:               o.wr = 1'b0;                // control ops
    endcase
    o.z  = (o.res == 8'h00);
    o.dc = nib[4];
    o.c  = sum[8];
  end

endmodule // csr_alu

// [design/csr_prescale.sv]
// Purpose: shared prescaler for timer zero or watchdog, plus watchdog divider
// Assumes: one tick per enabled clock is the instruction rate
// Notes:   clearing the watchdog also clears the prescaler when it is assigned there
`timescale 1ns/1ps
module csr_prescale #(
  parameter int unsigned WDT_BASE = csr_pkg::WDT_BASE_CYCLES
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       prescaler_assign_bit,
  input  wire logic [2:0] ps,
  input  wire logic       wdt_clear,
  output logic            t0_tick,
  output logic            wdt_expire
);

  if (WDT_BASE < 2 || WDT_BASE > 65536) begin : g_chk
    $error("WDT_BASE out of range");
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  logic [15:0] base_r, base_nxt;   // watchdog own divider
  logic [7:0]  pre_r, pre_nxt;     // shared prescaler
  logic        exp_r, exp_nxt;     // registered expiry pulse
  logic        base_tick;

  // rate mask: low n bits set
  function automatic logic [7:0] rate_mask(input logic [3:0] n);
    rate_mask = 8'((9'h001 << n) - 9'h001);
  endfunction

  assign wdt_expire = exp_r;

  // next state of the scalers
  always_comb begin
    base_tick = (base_r == 16'(WDT_BASE - 1));
    base_nxt  = base_tick ? 16'h0000 : base_r + 16'h0001;
    pre_nxt   = pre_r;
    // timer zero runs 1:1 while the prescaler serves the watchdog
    t0_tick   = prescaler_assign_bit ? 1'b1
                    : ((pre_r & rate_mask({1'b0, ps} + 4'h1)) ==
                        rate_mask({1'b0, ps} + 4'h1));
    exp_nxt   = prescaler_assign_bit ? (base_tick &&
                       ((pre_r & rate_mask({1'b0, ps})) == rate_mask({1'b0, ps})))
                    : base_tick;
    if (prescaler_assign_bit ? base_tick : 1'b1) begin
      pre_nxt = pre_r + 8'h01;
    end
    if (wdt_clear) begin
      base_nxt = 16'h0000;
      exp_nxt  = 1'b0;
      if (prescaler_assign_bit) begin
        pre_nxt = 8'h00;
      end
    end
  end

  // register the scalers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_r <= 16'h0000;
      pre_r  <= 8'h00;
      exp_r  <= 1'b0;
    end else if (ce) begin
      base_r <= base_nxt;
      pre_r  <= pre_nxt;
      exp_r  <= exp_nxt;
    end
  end

endmodule // csr_prescale

// [verification/csr_top_tb_top.sv]
// Purpose: self-checking bench for the core status register block
// Assumes: AXI4-Lite master tasks; watchdog base shortened to 4 cycles
// Notes:   expectations come from flag, bank and event rules, never the design
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module csr_top_tb_top;
  // ----------------------------------------------------------------
  // bus signals and counters
  // ----------------------------------------------------------------
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pin, ce;
  logic        awready, wready, bvalid, arready, rvalid, wdt_timeout;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data;
  logic [1:0]  bresp, rresp, rd_resp, wr_resp;
  logic [7:0]  t0;             // timer snapshot, also an edge count
  int          fail_count, comparisons;
  // code, file, w, expected status; event flags stay set throughout
  logic [27:0] alu_tbl [5] = '{{4'h0, 8'h01, 8'h0f, 8'h1a}, {4'h0, 8'hff, 8'h01, 8'h1f},
    {4'h1, 8'h05, 8'h05, 8'h1f}, {4'h1, 8'h00, 8'h01, 8'h18}, {4'h1, 8'h10, 8'h01, 8'h19}};
  // op word and expected status: bit set, bit clear, swap on status, then logic zero flag
  logic [39:0] st_tbl [6] = '{{32'h0983_0005, 8'h3d}, {32'h0883_0000, 8'h3c},
    {32'h0783_0000, 8'hdb}, {32'h0400_5a5a, 8'hdf}, {32'h0300_0100, 8'hdb},
    {32'h0200_f00f, 8'hdf}};

  csr_top #(.ADDR_W(12), .WDT_BASE(4)) csr_top_inst (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .input_only_pin(pin), .wdt_timeout(wdt_timeout));

  // ----------------------------------------------------------------
  // clock and bus tasks
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end
  // address and data offered together, held until taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do @(posedge aclk); while (awready !== 1'h1);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(posedge aclk); while (bvalid !== 1'h1);
    wr_resp = bresp;
    bready <= 1'h0;
    @(posedge aclk); // spare edge so the next call never re-drives in this step
  endtask
  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'h0;
    @(posedge aclk);
  endtask
  // instruction word: code, dest, file address, file value, w
  function automatic logic [31:0] op(logic [3:0] c, logic d, logic [6:0] a, logic [7:0] f,
                                     logic [7:0] w);
    return {4'h0, c, d, a, f, w};
  endfunction
  task automatic wrap_up;
    $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 56'h0;
    pin = 1'h1;
    ce = 1'h1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    wr(12'h004, 32'h0); // prescaler serves the watchdog at reset, so timer runs 1:1
    rd(12'h004);
    `CHK(rd_data, 32'h03)
    ce <= 1'h0; // frozen edges must not count
    repeat (5) @(posedge aclk);
    ce <= 1'h1;
    rd(12'h004);
    `CHK(rd_data, 32'h07)
    for (int i = 0; i < 4; i++) begin // every bank mirror sees one register
      rd({1'h0, i[1:0], 9'h00c});
      `CHK(rd_data, 32'h18)
    end
    wr(12'h00c, 32'h0);
    `CHK(wr_resp, csr_pkg::RESP_OKAY)
    rd(12'h20c);
    `CHK(rd_data, 32'h18)
    foreach (alu_tbl[i]) begin // add and subtract flag cases
      wr(12'h100, op(alu_tbl[i][27:24], 1'h0, 7'h00, alu_tbl[i][23:16], alu_tbl[i][15:8]));
      rd(12'h00c);
      `CHK(rd_data[7:0], alu_tbl[i][7:0])
    end
    wr(12'h100, op(4'h0, 1'h1, 7'h03, 8'h01, 8'h01)); // add aimed at status: flags beat data
    rd(12'h00c);
    `CHK(rd_data, 32'h18)
    wr(12'h00c, 32'he1);
    wr(12'h100, op(4'h5, 1'h1, 7'h03, 8'h00, 8'h00));
    rd(12'h00c);
    `CHK(rd_data, 32'h1d)
    foreach (st_tbl[i]) begin // status written as data by flag-neutral ops, then its z flag by logic ops
      wr(12'h100, st_tbl[i][39:8]);
      rd(12'h00c);
      `CHK(rd_data, {24'h0, st_tbl[i][7:0]})
    end
    wr(12'h108, 32'h42);
    for (int r = 0; r < 4; r++) begin // each bank pair and direct bank
      wr(12'h00c, {24'h0, r[1], r[1:0], 5'h00});
      wr(12'h100, op(4'h6, 1'h1, 7'h10, 8'h00, 8'h00));
      rd(12'h108);
      `CHK(rd_data, {7'h0, r[1], 8'h42, 7'h0, r[1:0], 7'h10})
    end
    wr(12'h028, 32'h15);
    wr(12'h100, op(4'hc, 1'h0, 7'h00, 8'h00, 8'h34));
    rd(12'h104);
    `CHK(rd_data[20:8], 13'h1534)
    wr(12'h214, 32'h0);
    rd(12'h214);
    `CHK(rd_data[5], 1'h1)
    pin <= 1'h0;
    rd(12'h014);
    `CHK(rd_data[5], 1'h0)
    pin <= 1'h1;
    rd(12'h014);
    `CHK(rd_data[5], 1'h1)
    rd(12'h3fc); // unmapped index
    `CHK(rd_resp, csr_pkg::RESP_SLVERR)
    `CHK(rd_data, 32'h0)
    wr(12'h3fc, 32'h0); // unmapped write is answered but changes nothing
    `CHK(wr_resp, csr_pkg::RESP_SLVERR)
    wr(12'h100, op(4'hb, 1'h0, 7'h00, 8'h00, 8'h00));
    rd(12'h00c);
    `CHK(rd_data[4:3], 2'h2)
    wr(12'h100, op(4'ha, 1'h0, 7'h00, 8'h00, 8'h00));
    rd(12'h00c);
    `CHK(rd_data[4:3], 2'h3)
    wr(12'h204, 32'h0); // prescaler to timer: watchdog runs on its own base divider
    for (int n = 0; n < 40 && wdt_timeout !== 1'h1; n++) @(posedge aclk);
    `CHK(wdt_timeout, 1'h1)
    t0 = 8'h00; // next pulse comes one base period of 4 edges later
    do begin @(posedge aclk); t0++; end while (wdt_timeout !== 1'h1 && t0 < 8'd40);
    `CHK(t0, 8'h04)
    rd(12'h00c);
    `CHK(rd_data[4], 1'h0)
    rd(12'h004); // prescaler now on the timer at 1:2, reads lie 4 edges apart
    t0 = rd_data[7:0];
    rd(12'h004);
    `CHK(8'(rd_data[7:0] - t0), 8'h02)
    wrap_up();
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #(3000 * 100);
    fail_count++;
    wrap_up();
  end
endmodule // csr_top_tb_top
